// File: common/ptp_cfg.svh
`ifndef PTP_CFG_SVH
`define PTP_CFG_SVH

// ==========================================================
// Register byte offsets
`define PTP_ADDR_CTRL     8'h00
`define PTP_ADDR_STATUS   8'h04
`define PTP_ADDR_RESULT   8'h08
`define PTP_ADDR_STB      8'h0C
`define PTP_ADDR_TXDATA   8'h10
`define PTP_ADDR_BAUD     8'h14
`define PTP_ADDR_IRQSTAT  8'h18
`define PTP_ADDR_IRQMASK  8'h1C

// ==========================================================
// Field positions
`define PTP_CTRL_PLC      0
`define PTP_CTRL_TALK     1
`define PTP_CTRL_MULTI    2
`define PTP_RES_STEP      0
`define PTP_RES_SEQ       1
`define PTP_RES_PASS      2
`define PTP_RES_FAIL      3
`define PTP_RES_ERR       4
`define PTP_RES_CODE_LSB  5
`define PTP_IRQ_START     0
`define PTP_IRQ_DISCH     1
`define PTP_IRQ_RELEASE   2
`define PTP_IRQ_OVERRUN   3

// ==========================================================
// Reset values and counts
`define PTP_BANK_OFFSET   9'h100
`define PTP_ERR_CODE_MAX  4'h4
`define PTP_CLK_HZ        200000000
`define PTP_BAUD_RATE     115200
`define PTP_BAUD_DIV_RST  16'(`PTP_CLK_HZ / `PTP_BAUD_RATE)
`define PTP_FRAME_BITS    4'hA

`endif

// File: common/ptp_pkg.sv
package ptp_pkg;

	// Gray codes along idle -> measure -> discharge
	typedef enum logic [1:0] {
		PTP_IDLE    = 2'h0,
		PTP_MEASURE = 2'h1,
		PTP_DISCH   = 2'h3
	} ptp_state_t;

	typedef enum logic [3:0] {
		PTP_ERR_SAFETY_LOOP = 4'h0,
		PTP_ERR_SATURATION  = 4'h1,
		PTP_ERR_OVER_RANGE  = 4'h2,
		PTP_ERR_CHARGE      = 4'h3,
		PTP_ERR_VOLTAGE     = 4'h4
	} ptp_err_t;

	typedef struct packed {
		ptp_state_t  state;
		logic        plc_en;
		logic        talker_en;
		logic        multi_run;
		logic [7:0]  stb;
		logic [15:0] baud_div;
		logic [3:0]  irq_stat;
		logic [3:0]  irq_mask;
		logic        meas_prev;
		logic [8:0]  setting;
		logic        granted;
		logic        test_done_flag;
		logic        pass;
		logic        fail;
		logic        err;
		logic [3:0]  err_code;
		logic        meas_start;
		logic [7:0]  txd;
		logic        txd_pend;
		logic        stb_pend;
		logic [31:0] rdata;
	} ptp_regs_t;

	typedef struct packed {
		logic [15:0] baud_cnt;
		logic [3:0]  bits_left;
		logic [9:0]  shift;
	} ptp_tx_t;

endpackage

// File: logic/ptp_sync.sv
`timescale 1ns/1ps
module ptp_sync #(
	parameter int W = 11
) (
	input  wire logic         mclk_i,
	input  wire logic         srst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} ptp_sync_t;

	ptp_sync_t st;
	ptp_sync_t next_st;

	always_comb begin
		next_st    = st;
		next_st.s1 = d_i;
		next_st.s2 = st.s1;
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign q_o = st.s2;

endmodule

// File: logic/ptp_uart_tx.sv
`timescale 1ns/1ps
`include "ptp_cfg.svh"
module ptp_uart_tx (
	input  wire logic        mclk_i,
	input  wire logic        srst_i,
	input  wire logic [15:0] div_i,
	input  wire logic        start_i,
	input  wire logic [7:0]  data_i,
	output logic             tx_o,
	output logic             busy_o
);

	ptp_pkg::ptp_tx_t st;
	ptp_pkg::ptp_tx_t next_st;

	// ==========================================================
	// 8N1 frame, LSB first, idle high
	always_comb begin
		next_st = st;
		if (st.bits_left == 4'h0) begin
			if (start_i) begin
				next_st.shift     = {1'b1, data_i, 1'b0};
				next_st.bits_left = `PTP_FRAME_BITS;
				next_st.baud_cnt  = div_i;
			end
		end else if (st.baud_cnt <= 16'h0001) begin
			next_st.shift     = {1'b1, st.shift[9:1]};
			next_st.bits_left = st.bits_left - 4'h1;
			next_st.baud_cnt  = div_i;
		end else begin
			next_st.baud_cnt = st.baud_cnt - 16'h0001;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			st <= '{baud_cnt: 16'h0000, bits_left: 4'h0, shift: 10'h3FF};
		end else begin
			st <= next_st;
		end
	end

	assign tx_o   = (st.bits_left == 4'h0) ? 1'b1 : st.shift[0];
	assign busy_o = (st.bits_left != 4'h0);

endmodule

// File: logic/ptp_top.sv
`timescale 1ns/1ps
`include "ptp_cfg.svh"
module ptp_top (
	input  wire logic        mclk_i,
	input  wire logic        srst_i,
	input  wire logic        control_request_in_i,
	input  wire logic        bank_select_i,
	input  wire logic [7:0]  setting_number_i,
	input  wire logic        measure_discharge_select_i,
	output logic             control_granted_out_o,
	output logic             test_done_flag_o,
	output logic             pass_result_out_o,
	output logic             fail_result_out_o,
	output logic             error_o,
	output logic [3:0]       error_type_o,
	output logic             meas_run_o,
	output logic             discharge_o,
	output logic             meas_start_o,
	output logic [8:0]       setting_sel_o,
	output logic             serial_tx_o,
	output logic             irq_o,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic [31:0]      rdata_o
);

	ptp_pkg::ptp_regs_t q;
	ptp_pkg::ptp_regs_t next_q;

	logic       req_s;
	logic       bank_s;
	logic [7:0] num_s;
	logic       meas_s;
	logic       rise;
	logic       fall_lvl;
	logic       talker_ok;
	logic       tx_busy;
	logic       tx_start;
	logic [7:0] tx_byte;
	logic       wr_res;
	logic       wr_txd;
	logic [3:0] res_code;
	logic [3:0] irq_set;

	function automatic logic code_ok(input logic [3:0] c);
		code_ok = (c <= `PTP_ERR_CODE_MAX);
	endfunction

	// ==========================================================
	// Pin inputs, two flops each
	ptp_sync #(
		.W(11)
	) u_sync (
		.mclk_i (mclk_i),
		.srst_i (srst_i),
		.d_i    ({control_request_in_i, bank_select_i, setting_number_i,
		          measure_discharge_select_i}),
		.q_o    ({req_s, bank_s, num_s, meas_s})
	);

	// ==========================================================
	// Serial talker
	ptp_uart_tx u_tx (
		.mclk_i  (mclk_i),
		.srst_i  (srst_i),
		.div_i   (q.baud_div),
		.start_i (tx_start),
		.data_i  (tx_byte),
		.tx_o    (serial_tx_o),
		.busy_o  (tx_busy)
	);

	assign rise      = meas_s & ~q.meas_prev;
	assign fall_lvl  = ~meas_s;
	assign talker_ok = q.plc_en & q.talker_en;
	assign wr_res    = wr_i && (addr_i == `PTP_ADDR_RESULT);
	assign wr_txd    = wr_i && (addr_i == `PTP_ADDR_TXDATA);
	assign res_code  = wdata_i[`PTP_RES_CODE_LSB +: 4];
	// Result text goes ahead of the status byte so the status byte lands last
	assign tx_start  = ~tx_busy & (q.txd_pend | q.stb_pend);
	assign tx_byte   = q.txd_pend ? q.txd : q.stb;

	// ==========================================================
	// Next state
	always_comb begin
		next_q            = q;
		next_q.meas_prev  = meas_s;
		next_q.meas_start = 1'b0;
		irq_set           = 4'h0;

		// Handshake, ignored unless controller mode is on
		if (q.plc_en) begin
			if (rise) begin
				if (req_s) begin
					next_q.state      = ptp_pkg::PTP_MEASURE;
					next_q.setting    = bank_s ? {1'b0, num_s}
					                  : ({1'b0, num_s} + `PTP_BANK_OFFSET);
					next_q.test_done_flag        = 1'b0;
					next_q.pass       = 1'b0;
					next_q.fail       = 1'b0;
					next_q.err        = 1'b0;
					next_q.meas_start = 1'b1;
					irq_set[`PTP_IRQ_START] = 1'b1;
				end else begin
					// Low request captured: hand back local control
					if (q.granted) begin
						irq_set[`PTP_IRQ_RELEASE] = 1'b1;
					end
					next_q.granted = 1'b0;
					next_q.state   = ptp_pkg::PTP_IDLE;
				end
			end else if (fall_lvl && q.state == ptp_pkg::PTP_MEASURE) begin
				next_q.state = ptp_pkg::PTP_DISCH;
				irq_set[`PTP_IRQ_DISCH] = 1'b1;
			end
		end

		// Sent bytes retire first, so a new request in the same cycle wins
		if (tx_start) begin
			if (q.txd_pend) begin
				next_q.txd_pend = 1'b0;
			end else begin
				next_q.stb_pend = 1'b0;
			end
		end

		// Test progress reported by the instrument core
		if (wr_res && q.plc_en && q.state != ptp_pkg::PTP_IDLE) begin
			if (wdata_i[`PTP_RES_STEP]) begin
				next_q.granted = 1'b1;
			end
			if (wdata_i[`PTP_RES_SEQ]) begin
				next_q.test_done_flag  = 1'b1;
				next_q.pass = wdata_i[`PTP_RES_PASS];
				next_q.fail = wdata_i[`PTP_RES_FAIL] & ~wdata_i[`PTP_RES_PASS];
				if (talker_ok) begin
					next_q.stb_pend = 1'b1;
				end
			end
			// Undefined codes dropped, so 5..15 never reach the pins
			if (wdata_i[`PTP_RES_ERR] && code_ok(res_code)) begin
				next_q.err      = 1'b1;
				next_q.err_code = res_code;
			end
		end

		// Result text bytes; single holding byte, no queue
		if (wr_txd && talker_ok) begin
			if (q.txd_pend && !tx_start) begin
				irq_set[`PTP_IRQ_OVERRUN] = 1'b1;
			end else begin
				next_q.txd      = wdata_i[7:0];
				next_q.txd_pend = 1'b1;
			end
		end
		if (!talker_ok) begin
			next_q.txd_pend = 1'b0;
			next_q.stb_pend = 1'b0;
		end

		// Register writes
		if (wr_i) begin
			unique case (addr_i)
				`PTP_ADDR_CTRL: begin
					next_q.plc_en    = wdata_i[`PTP_CTRL_PLC];
					next_q.talker_en = wdata_i[`PTP_CTRL_TALK];
					next_q.multi_run = wdata_i[`PTP_CTRL_MULTI];
				end
				`PTP_ADDR_STB:     next_q.stb      = wdata_i[7:0];
				`PTP_ADDR_BAUD:    next_q.baud_div = wdata_i[15:0];
				`PTP_ADDR_IRQMASK: next_q.irq_mask = wdata_i[3:0];
				`PTP_ADDR_IRQSTAT: next_q.irq_stat = q.irq_stat & ~wdata_i[3:0];
				default: ;
			endcase
		end
		// Set wins: an event in the clearing cycle stays pending
		next_q.irq_stat = next_q.irq_stat | irq_set;
		if (!q.plc_en) begin
			next_q.state   = ptp_pkg::PTP_IDLE;
			next_q.granted = 1'b0;
		end

		// Register reads, answer in the next cycle
		next_q.rdata = 32'h0000_0000;
		if (rd_i) begin
			unique case (addr_i)
				`PTP_ADDR_CTRL:    next_q.rdata = {29'h0, q.multi_run, q.talker_en, q.plc_en};
				`PTP_ADDR_STATUS:  next_q.rdata = {17'h0, q.setting, q.stb_pend, q.txd_pend,
				                                   tx_busy, q.granted, q.state};
				`PTP_ADDR_STB:     next_q.rdata = {24'h0, q.stb};
				`PTP_ADDR_BAUD:    next_q.rdata = {16'h0, q.baud_div};
				`PTP_ADDR_IRQSTAT: next_q.rdata = {28'h0, q.irq_stat};
				`PTP_ADDR_IRQMASK: next_q.rdata = {28'h0, q.irq_mask};
				default:           next_q.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			q          <= '0;
			q.state    <= ptp_pkg::PTP_IDLE;
			q.baud_div <= `PTP_BAUD_DIV_RST;
		end else begin
			q <= next_q;
		end
	end

	// ==========================================================
	// Outputs; flags active high, serial_tx_o idles high with a low start bit
	assign control_granted_out_o = q.granted;
	assign test_done_flag_o      = q.test_done_flag;
	assign pass_result_out_o     = q.pass;
	assign fail_result_out_o     = q.fail;
	assign error_o               = q.err;
	assign error_type_o          = q.err_code;
	assign meas_run_o            = (q.state == ptp_pkg::PTP_MEASURE);
	assign discharge_o           = (q.state == ptp_pkg::PTP_DISCH);
	assign meas_start_o          = q.meas_start;
	assign setting_sel_o         = q.setting;
	assign irq_o                 = |(q.irq_stat & q.irq_mask);
	assign rdata_o               = q.rdata;

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);

	property p_err_code_range;
		code_ok(error_type_o);
	endproperty
	a_err_code_range: assert property (p_err_code_range)
		else $error("error type code out of range");

	property p_err_report;
		wr_res && q.plc_en && q.state != ptp_pkg::PTP_IDLE && wdata_i[`PTP_RES_ERR]
		&& code_ok(res_code)
		|=> error_o && error_type_o == $past(res_code);
	endproperty
	a_err_report: assert property (p_err_report)
		else $error("error not reported with its code");

	property p_bank_offset;
		q.plc_en && rise && req_s && !bank_s
		|=> setting_sel_o == ({1'b0, $past(num_s)} + `PTP_BANK_OFFSET);
	endproperty
	a_bank_offset: assert property (p_bank_offset)
		else $error("lower bank offset not applied");

	property p_sample_on_edge;
		!rise |=> $stable(setting_sel_o);
	endproperty
	a_sample_on_edge: assert property (p_sample_on_edge)
		else $error("setting changed without a measure edge");

	property p_grant_on_done;
		wr_res && wdata_i[`PTP_RES_STEP] && q.plc_en && q.state != ptp_pkg::PTP_IDLE
		|=> control_granted_out_o [*2];
	endproperty
	a_grant_on_done: assert property (p_grant_on_done)
		else $error("control not granted after first measurement");

	property p_grant_held;
		control_granted_out_o && q.plc_en && !(rise && !req_s) && !wr_i
		|=> control_granted_out_o;
	endproperty
	a_grant_held: assert property (p_grant_held)
		else $error("grant dropped without a captured low request");

	property p_discharge;
		meas_run_o && q.plc_en && !meas_s && !wr_i |=> discharge_o && !meas_run_o;
	endproperty
	a_discharge: assert property (p_discharge)
		else $error("no discharge after measure went low");

	property p_ignore_off;
		!q.plc_en && rise |=> !meas_start_o && !meas_run_o;
	endproperty
	a_ignore_off: assert property (p_ignore_off)
		else $error("inputs acted on outside controller mode");

	property p_verdict;
		wr_res && q.plc_en && q.state != ptp_pkg::PTP_IDLE && wdata_i[`PTP_RES_SEQ]
		&& wdata_i[`PTP_RES_PASS]
		|=> test_done_flag_o && pass_result_out_o && !fail_result_out_o;
	endproperty
	a_verdict: assert property (p_verdict)
		else $error("end of test or pass verdict missing");

	property p_stb_send;
		wr_res && talker_ok && q.state != ptp_pkg::PTP_IDLE && wdata_i[`PTP_RES_SEQ]
		|=> q.stb_pend;
	endproperty
	a_stb_send: assert property (p_stb_send)
		else $error("status byte not queued at end of run");

	property p_talker_gate;
		!talker_ok |=> !tx_start;
	endproperty
	a_talker_gate: assert property (p_talker_gate)
		else $error("serial send outside talker mode");

	property p_text_prompt;
		q.txd_pend && !tx_busy |-> tx_start ##1 tx_busy;
	endproperty
	a_text_prompt: assert property (p_text_prompt)
		else $error("result byte not sent when link idle");

	property p_start_pulse;
		meas_start_o |=> !meas_start_o;
	endproperty
	a_start_pulse: assert property (p_start_pulse)
		else $error("start pulse longer than one cycle");

	property p_verdict_excl;
		!(pass_result_out_o && fail_result_out_o);
	endproperty
	a_verdict_excl: assert property (p_verdict_excl)
		else $error("pass and fail shown together");

	property p_release;
		q.plc_en && rise && !req_s && !wr_i |=> !control_granted_out_o && !meas_run_o;
	endproperty
	a_release: assert property (p_release)
		else $error("grant kept after a captured low request");

endmodule

// File: verification/ptp_plc_model.sv
`timescale 1ns/1ps
// ==========================================================
// Controller side of the pin link
module ptp_plc_model (
	input  wire logic       mclk_i,
	output logic            req_o,
	output logic            bank_o,
	output logic [7:0]      num_o,
	output logic            meas_o
);
	initial begin
		req_o = 1'b0;
		bank_o = 1'b1;
		num_o = 8'h00;
		meas_o = 1'b0;
	end

	// Levels settle a cycle ahead of the measure edge
	task automatic pins(input logic req, input logic bank, input logic [7:0] num);
		@(posedge mclk_i);
		req_o <= req;
		bank_o <= bank;
		num_o <= num;
	endtask

	// Eight cycles cover the synchroniser and edge detector
	task automatic measure(input logic req, input logic bank, input logic [7:0] num);
		pins(req, bank, num);
		@(posedge mclk_i);
		meas_o <= 1'b1;
		repeat (8) @(posedge mclk_i);
	endtask

	task automatic discharge();
		@(posedge mclk_i);
		meas_o <= 1'b0;
		repeat (8) @(posedge mclk_i);
	endtask
endmodule

// File: verification/tb_top.sv
`timescale 1ns/1ps
`include "ptp_cfg.svh"
module tb_top;
	logic        mclk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic        req, bank, meas;
	logic [7:0]  num;
	logic        granted, done, pass, fail, err, run, disch, mstart, txd, irq;
	logic [3:0]  etype;
	logic [8:0]  sel;
	logic [7:0]  addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic [31:0] rdata_o;
	int          fail_count = 0;
	int          tests_run = 0;
	int          starts = 0;

	always #2.5 mclk_i = ~mclk_i;

	// Count start pulses away from the edge that launches them
	always @(negedge mclk_i) begin
		if (mstart === 1'b1) begin
			starts++;
		end
	end

	ptp_plc_model plc (.mclk_i(mclk_i), .req_o(req), .bank_o(bank), .num_o(num), .meas_o(meas));

	ptp_top dut (
		.mclk_i(mclk_i), .srst_i(srst_i), .control_request_in_i(req), .bank_select_i(bank),
		.setting_number_i(num), .measure_discharge_select_i(meas),
		.control_granted_out_o(granted), .test_done_flag_o(done), .pass_result_out_o(pass),
		.fail_result_out_o(fail), .error_o(err), .error_type_o(etype), .meas_run_o(run),
		.discharge_o(disch), .meas_start_o(mstart), .setting_sel_o(sel), .serial_tx_o(txd),
		.irq_o(irq), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o)
	);

	// ==========================================================
	// Shared tasks
	task automatic finish_test();
		$display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1;
		chk(rdata_o, exp);
	endtask

	// Baud divider is 4 here, so data bit i is sampled 6 + 4*i cycles after the start edge
	task automatic rx(input logic [7:0] exp);
		logic [7:0] b;
		int         n;
		n = 0;
		while (txd !== 1'b0 && n < 400) begin
			cyc(1);
			n++;
		end
		if (n == 400) begin
			chk(32'h0, 32'h1);
			finish_test();
		end else begin
			cyc(2);
			for (int i = 0; i < 8; i++) begin
				cyc(4);
				b[i] = txd;
			end
			cyc(4);
			chk(32'(b), 32'(exp));
			chk(32'(txd), 32'h1);
		end
	endtask

	task automatic done_msg(input string s);
		$display("test %s done", s);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		repeat (20) @(posedge mclk_i);
		srst_i <= 1'b0;
		cyc(4);
		chk(32'({granted, done, pass, fail, err, run, irq, txd}), 32'h1);
		rchk(`PTP_ADDR_BAUD, 32'h6C8);
		rchk(8'h40, 32'h0);
		done_msg("reset");

		plc.measure(1'b1, 1'b0, 8'h05);
		cyc(1);
		chk(32'({run, granted}), 32'h0);
		chk(32'(starts), 32'h0);
		plc.discharge();
		done_msg("disabled");

		wr(`PTP_ADDR_CTRL, 32'h1);
		wr(`PTP_ADDR_BAUD, 32'h4);
		wr(`PTP_ADDR_IRQMASK, 32'h0);
		plc.measure(1'b1, 1'b0, 8'h05);
		cyc(1);
		chk(32'(sel), 32'h105);
		chk(32'(run), 32'h1);
		chk(32'(starts), 32'h1);
		rchk(`PTP_ADDR_STATUS, 32'h4141);
		rchk(`PTP_ADDR_IRQSTAT, 32'h1);
		chk(32'(irq), 32'h0);
		wr(`PTP_ADDR_IRQMASK, 32'h1);
		cyc(2);
		chk(32'(irq), 32'h1);
		wr(`PTP_ADDR_IRQSTAT, 32'h1);
		cyc(2);
		chk(32'(irq), 32'h0);
		done_msg("start");

		// Pin changes mid-measurement must not reach the latched number
		plc.pins(1'b0, 1'b1, 8'h22);
		cyc(8);
		chk(32'(sel), 32'h105);
		chk(32'({run, granted}), 32'h2);
		wr(`PTP_ADDR_RESULT, 32'h1);
		cyc(2);
		chk(32'(granted), 32'h1);
		done_msg("hold");

		for (int c = 0; c < 5; c++) begin
			wr(`PTP_ADDR_RESULT, 32'h10 | (32'(c) << 5));
			cyc(2);
			chk(32'({err, etype}), 32'h10 | 32'(c));
		end
		wr(`PTP_ADDR_RESULT, 32'hF0);
		cyc(2);
		chk(32'(etype), 32'h4);
		wr(`PTP_ADDR_RESULT, 32'h6);
		cyc(2);
		chk(32'({done, pass, fail}), 32'h6);
		wr(`PTP_ADDR_RESULT, 32'hA);
		cyc(2);
		chk(32'({done, pass, fail}), 32'h5);
		done_msg("results");

		wr(`PTP_ADDR_CTRL, 32'h7);
		rchk(`PTP_ADDR_CTRL, 32'h7);
		wr(`PTP_ADDR_TXDATA, 32'hA5);
		rx(8'hA5);
		wr(`PTP_ADDR_STB, 32'h41);
		wr(`PTP_ADDR_RESULT, 32'h2);
		rx(8'h41);
		done_msg("talker");

		plc.discharge();
		cyc(1);
		chk(32'({disch, run, granted}), 32'h5);
		plc.measure(1'b1, 1'b1, 8'hFF);
		cyc(1);
		chk(32'(sel), 32'hFF);
		chk(32'({done, granted}), 32'h1);
		chk(32'(starts), 32'h2);
		done_msg("second");

		plc.discharge();
		plc.measure(1'b0, 1'b1, 8'hFF);
		cyc(1);
		chk(32'({run, granted}), 32'h0);
		plc.discharge();
		cyc(1);
		chk(32'(granted), 32'h0);
		chk(32'(starts), 32'h2);
		rchk(`PTP_ADDR_IRQSTAT, 32'h7);
		done_msg("release");
		finish_test();
	end
endmodule
